// ==== src/wkctl_defines.svh ====
// Register offsets, field positions and timing figures of the wake control block.
`ifndef WKCTL_DEFINES_SVH
`define WKCTL_DEFINES_SVH
`define WKCTL_ADDR_W 12
`define WKCTL_OFF_INT_STS 12'h058
`define WKCTL_OFF_INT_EN 12'h05c
`define WKCTL_OFF_HARDWARE_CONFIG_REG 12'h074
`define WKCTL_OFF_PWC 12'h084
`define WKCTL_OFF_RST_CTL 12'h1f8
`define WKCTL_B_READY 0
`define WKCTL_B_PIN_EN 1
`define WKCTL_B_POL 2
`define WKCTL_B_PULSE 3
`define WKCTL_B_FLAG 5
`define WKCTL_B_DRIVE 6
`define WKCTL_B_LAN_EN 9
`define WKCTL_B_HW_READY 27
`define WKCTL_PWC_MASK 32'h0000_026f
`define WKCTL_B_SRST 0
`define WKCTL_B_DRST 0
`define WKCTL_IRQ_READY 0
`define WKCTL_IRQ_WAKE 1
`define WKCTL_IRQ_W 2
`define WKCTL_RDY_W 8
`define WKCTL_READY_CYC 8'h10
`define WKCTL_PULSE_MS 50
`define WKCTL_CLK_KHZ 100000
`define WKCTL_CNT_W 23
`endif

// ==== src/wkctl_pkg.sv ====
// Types shared by the wake control block.
package wkctl_pkg;
`include "wkctl_defines.svh"

typedef enum logic [2:0] {
    WKCTL_REG_NONE, WKCTL_REG_PWC, WKCTL_REG_HWC, WKCTL_REG_ISTS, WKCTL_REG_IEN, WKCTL_REG_RCTL
} wkctl_reg_e;

typedef enum logic {WKCTL_ST_SETTLE, WKCTL_ST_READY} wkctl_phase_e;

typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`WKCTL_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
} wkctl_apb_req_s;

typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
} wkctl_apb_rsp_s;

typedef struct packed {
    logic o;
    logic oe;
} wkctl_pin_s;

typedef struct packed {
    wkctl_phase_e phase;
    logic [`WKCTL_RDY_W-1:0] rdy_cnt;
    logic lan_wake_enable;
    logic wake_out_drive_sel;
    logic lan_wake_flag;
    logic wake_pulse_sel;
    logic wake_out_polarity;
    logic wake_pin_enable;
    logic [`WKCTL_IRQ_W-1:0] int_sts;
    logic [`WKCTL_IRQ_W-1:0] int_en;
    logic evt_d;
    logic wake_act;
    logic ack;
    logic slverr;
    logic [31:0] rdata;
    wkctl_pin_s pin;
    logic irq;
} wkctl_state_s;

typedef struct packed {
    logic busy;
    logic [`WKCTL_CNT_W-1:0] cnt;
} wkctl_tmr_s;

endpackage

// ==== src/wkctl_pulse_timer.sv ====
// Retriggerable one-shot that times the pulsed wake indication.
`timescale 1ns/1ns
module wkctl_pulse_timer import wkctl_pkg::*; #(
    parameter int unsigned CYCLES = 5000000
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_cancel,
    output logic o_busy
);

wkctl_tmr_s st;
wkctl_tmr_s next_st;

always_comb begin
    next_st = st;
    if (i_start) begin
        next_st.busy = 1'b1;
        next_st.cnt = `WKCTL_CNT_W'(CYCLES - 1);
    end else if (i_cancel) begin
        next_st.busy = 1'b0;
    end else if (st.busy) begin
        if (st.cnt == '0) begin
            next_st.busy = 1'b0;
        end else begin
            next_st.cnt = st.cnt - `WKCTL_CNT_W'(1);
        end
    end
end

always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
        st <= '0;
    end else begin
        st <= next_st;
    end
end

assign o_busy = st.busy;

default clocking tcb @(posedge i_clk_sys); endclocking
default disable iff (i_rst);

pulse_start_a: assert property (i_start ##1 !i_cancel |-> o_busy ##1 o_busy)
    else $error("pulse did not start");

endmodule // wkctl_pulse_timer

// ==== src/wkctl_top.sv ====
// Wake event output control, device ready flag and interrupt logic behind an APB slave.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module wkctl_top import wkctl_pkg::*; #(
    parameter int unsigned PULSE_CYC = `WKCTL_PULSE_MS * `WKCTL_CLK_KHZ
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wkctl_apb_req_s i_apb,
    output wkctl_apb_rsp_s o_apb,
    input wire logic i_lan_wake_evt,
    output wkctl_pin_s o_wake_event_out,
    output logic o_irq
);

// ----------------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------------

function automatic wkctl_reg_e reg_sel(input logic [`WKCTL_ADDR_W-1:0] addr);
    case (addr)
        `WKCTL_OFF_PWC: reg_sel = WKCTL_REG_PWC;
        `WKCTL_OFF_HARDWARE_CONFIG_REG: reg_sel = WKCTL_REG_HWC;
        `WKCTL_OFF_INT_STS: reg_sel = WKCTL_REG_ISTS;
        `WKCTL_OFF_INT_EN: reg_sel = WKCTL_REG_IEN;
        `WKCTL_OFF_RST_CTL: reg_sel = WKCTL_REG_RCTL;
        default: reg_sel = WKCTL_REG_NONE;
    endcase
endfunction

// ----------------------------------------------------------------------
// State
// ----------------------------------------------------------------------

wkctl_state_s st;
wkctl_state_s next_st;
wkctl_reg_e sel;
logic setup;
logic wr;
logic rdy;
logic evt_rise;
logic pulse_start;
logic pulse_busy;
logic do_srst;
logic act;
logic [`WKCTL_IRQ_W-1:0] irq_set;
logic [`WKCTL_IRQ_W-1:0] irq_clr;
logic [31:0] pwc_val;

wkctl_pulse_timer #(
    .CYCLES(PULSE_CYC)
) u_pulse (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_start(pulse_start),
    .i_cancel(do_srst),
    .o_busy(pulse_busy)
);

// ----------------------------------------------------------------------
// Next state
// ----------------------------------------------------------------------

always_comb begin
    next_st = st;
    sel = reg_sel(i_apb.paddr);
    rdy = (st.phase == WKCTL_ST_READY);
    setup = i_apb.psel & ~i_apb.penable;
    // Writes land only at the access edge and only once the device is ready.
    wr = i_apb.psel & i_apb.penable & st.ack & i_apb.pwrite & rdy;
    evt_rise = i_lan_wake_evt & ~st.evt_d;
    pulse_start = evt_rise & st.lan_wake_enable;
    do_srst = wr & (((sel == WKCTL_REG_HWC) & i_apb.pwdata[`WKCTL_B_SRST])
        | ((sel == WKCTL_REG_RCTL) & i_apb.pwdata[`WKCTL_B_DRST]));

    pwc_val = '0;
    pwc_val[`WKCTL_B_LAN_EN] = st.lan_wake_enable;
    pwc_val[`WKCTL_B_DRIVE] = st.wake_out_drive_sel;
    pwc_val[`WKCTL_B_FLAG] = st.lan_wake_flag;
    pwc_val[`WKCTL_B_PULSE] = st.wake_pulse_sel;
    pwc_val[`WKCTL_B_POL] = st.wake_out_polarity;
    pwc_val[`WKCTL_B_PIN_EN] = st.wake_pin_enable;
    pwc_val[`WKCTL_B_READY] = rdy;

    next_st.evt_d = i_lan_wake_evt;
    next_st.ack = setup;
    next_st.slverr = setup & (sel == WKCTL_REG_NONE);
    if (setup) begin
        next_st.rdata = '0;
        case (sel)
            WKCTL_REG_PWC: next_st.rdata = pwc_val;
            WKCTL_REG_HWC: next_st.rdata[`WKCTL_B_HW_READY] = rdy;
            WKCTL_REG_ISTS: next_st.rdata[`WKCTL_IRQ_W-1:0] = st.int_sts;
            WKCTL_REG_IEN: next_st.rdata[`WKCTL_IRQ_W-1:0] = st.int_en;
            default: next_st.rdata = '0;
        endcase
    end

    if (wr && sel == WKCTL_REG_PWC) begin
        next_st.lan_wake_enable = i_apb.pwdata[`WKCTL_B_LAN_EN];
        next_st.wake_out_drive_sel = i_apb.pwdata[`WKCTL_B_DRIVE];
        next_st.wake_pulse_sel = i_apb.pwdata[`WKCTL_B_PULSE];
        next_st.wake_out_polarity = i_apb.pwdata[`WKCTL_B_POL];
        next_st.wake_pin_enable = i_apb.pwdata[`WKCTL_B_PIN_EN];
    end
    if (wr && sel == WKCTL_REG_IEN) begin
        next_st.int_en = i_apb.pwdata[`WKCTL_IRQ_W-1:0];
    end

    // A pending event keeps the flag up, so a clear only sticks once the source drops.
    next_st.lan_wake_flag = i_lan_wake_evt | (st.lan_wake_flag
        & ~(wr & (sel == WKCTL_REG_PWC) & i_apb.pwdata[`WKCTL_B_FLAG]));

    irq_set = '0;
    irq_set[`WKCTL_IRQ_WAKE] = evt_rise & st.lan_wake_enable;
    irq_clr = (wr && sel == WKCTL_REG_ISTS) ? i_apb.pwdata[`WKCTL_IRQ_W-1:0] : '0;

    case (st.phase)
        WKCTL_ST_SETTLE: begin
            next_st.rdy_cnt = st.rdy_cnt + `WKCTL_RDY_W'(1);
            if (st.rdy_cnt == `WKCTL_READY_CYC - `WKCTL_RDY_W'(1)) begin
                next_st.phase = WKCTL_ST_READY;
                irq_set[`WKCTL_IRQ_READY] = 1'b1;
            end
        end
        WKCTL_ST_READY: next_st.rdy_cnt = '0;
        default: next_st.phase = WKCTL_ST_SETTLE;
    endcase
    next_st.int_sts = irq_set | (st.int_sts & ~irq_clr);

    // Pulsed mode is encoded as zero, following the listed field encoding.
    act = st.wake_pin_enable & st.lan_wake_enable & st.lan_wake_flag
        & (st.wake_pulse_sel | pulse_busy);
    next_st.wake_act = act;
    if (st.wake_out_drive_sel) begin
        next_st.pin.oe = 1'b1;
        next_st.pin.o = st.wake_out_polarity ? act : ~act;
    end else begin
        // Wired-OR line: only ever pulled low, released otherwise.
        next_st.pin.oe = act;
        next_st.pin.o = 1'b0;
    end
    next_st.irq = |(next_st.int_sts & next_st.int_en);

    if (do_srst) begin
        next_st.phase = WKCTL_ST_SETTLE;
        next_st.rdy_cnt = '0;
        next_st.lan_wake_enable = 1'b0;
        next_st.lan_wake_flag = 1'b0;
        next_st.wake_pulse_sel = 1'b0;
        next_st.wake_pin_enable = 1'b0;
        next_st.int_sts = '0;
        next_st.int_en = '0;
        next_st.irq = 1'b0;
        next_st.wake_out_drive_sel = st.wake_out_drive_sel;
        next_st.wake_out_polarity = st.wake_out_polarity;
    end
end

// ----------------------------------------------------------------------
// Registers and outputs
// ----------------------------------------------------------------------

always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
        st <= '0;
    end else begin
        st <= next_st;
    end
end

assign o_apb.pready = st.ack & i_apb.psel & i_apb.penable;
assign o_apb.pslverr = st.slverr & o_apb.pready;
assign o_apb.prdata = st.rdata;
assign o_wake_event_out = st.pin;
assign o_irq = st.irq;

// ----------------------------------------------------------------------
// Assertions
// ----------------------------------------------------------------------

default clocking cb @(posedge i_clk_sys); endclocking
default disable iff (i_rst);

sequence srst_s;
    do_srst;
endsequence

sequence pwc_early_write_s;
    i_apb.psel && i_apb.penable && st.ack && i_apb.pwrite && !rdy
        && sel == WKCTL_REG_PWC;
endsequence

sequence lan_event_s;
    evt_rise && st.lan_wake_enable && !do_srst;
endsequence

push_pull_a: assert property ($past(st.wake_out_drive_sel) |-> o_wake_event_out.oe)
    else $error("push-pull pin not driven");
open_drain_a: assert property (!$past(st.wake_out_drive_sel) |-> !o_wake_event_out.o)
    else $error("open-drain pin driven high");
flag_set_a: assert property (i_lan_wake_evt && !do_srst |=> st.lan_wake_flag)
    else $error("wake flag not set by event");
flag_hold_a: assert property (st.lan_wake_flag && i_lan_wake_evt && !do_srst |=> st.lan_wake_flag)
    else $error("wake flag cleared while event pending");
drop_out_a: assert property (!st.lan_wake_flag || !st.lan_wake_enable |=> !st.wake_act)
    else $error("wake output not dropped");
polarity_a: assert property ($past(st.wake_out_drive_sel && st.wake_out_polarity)
    |-> o_wake_event_out.o == st.wake_act)
    else $error("active high level wrong");
pin_gate_a: assert property (!st.wake_pin_enable |=> !st.wake_act)
    else $error("wake output active while pin disabled");
irq_any_pin_a: assert property (lan_event_s |=> st.int_sts[`WKCTL_IRQ_WAKE])
    else $error("wake interrupt flag not set");
ready_low_a: assert property (srst_s |=> !rdy [*8])
    else $error("ready high too soon after reset");
ready_irq_a: assert property ($rose(rdy) |-> st.int_sts[`WKCTL_IRQ_READY]
    && (!st.int_en[`WKCTL_IRQ_READY] || o_irq))
    else $error("ready interrupt missing");
early_write_a: assert property (pwc_early_write_s |=> $stable(st.wake_pin_enable))
    else $error("write honoured before ready");
ready_mirror_a: assert property (setup && sel == WKCTL_REG_HWC
    |=> o_apb.prdata[`WKCTL_B_HW_READY] == $past(rdy))
    else $error("config ready bit differs");
keep_drive_a: assert property (srst_s |=> $stable(st.wake_out_drive_sel))
    else $error("drive select lost on soft reset");
pulse_off_a: assert property (!st.wake_pulse_sel && !pulse_busy |=> !st.wake_act)
    else $error("pulse outlived its timer");

// The settle counter starts one edge after the reset write lands.
localparam int READY_LAT = `WKCTL_READY_CYC + 1;

sequence flag_clear_s;
    wr && sel == WKCTL_REG_PWC && i_apb.pwdata[`WKCTL_B_FLAG] && !i_lan_wake_evt;
endsequence

sequence wake_armed_s;
    st.lan_wake_enable && st.lan_wake_flag && st.wake_pin_enable;
endsequence

sequence pwc_read_s;
    setup && sel == WKCTL_REG_PWC;
endsequence

flag_clear_a: assert property (flag_clear_s |=> !st.lan_wake_flag)
    else $error("wake flag not cleared by write");
cont_drive_a: assert property (wake_armed_s ##0 st.wake_pulse_sel |=> st.wake_act)
    else $error("continuous wake output not driven");
pulse_drive_a: assert property (wake_armed_s ##0 pulse_busy |=> st.wake_act)
    else $error("pulsed wake output not driven");
pulse_run_a: assert property (pulse_start |=> pulse_busy)
    else $error("pulse timer not restarted");
// The pin and activity registers load on the same edge from the settings of the cycle before, so those settings are the past ones.
pin_level_a: assert property ($past(st.wake_out_drive_sel) && st.wake_act
    |-> o_wake_event_out.o == $past(st.wake_out_polarity))
    else $error("push-pull active level wrong");
pin_idle_a: assert property ($past(st.wake_out_drive_sel) && !st.wake_act
    |-> o_wake_event_out.o != $past(st.wake_out_polarity))
    else $error("push-pull idle level wrong");
od_release_a: assert property (!$past(st.wake_out_drive_sel)
    |-> o_wake_event_out.oe == st.wake_act)
    else $error("open-drain enable does not follow activity");
no_lan_irq_a: assert property (!st.int_sts[`WKCTL_IRQ_WAKE]
    && !(evt_rise && st.lan_wake_enable) |=> !st.int_sts[`WKCTL_IRQ_WAKE])
    else $error("wake interrupt set without enabled event");
irq_level_a: assert property (o_irq == |(st.int_sts & st.int_en))
    else $error("interrupt line differs from masked status");
// Reserved bits must read zero, otherwise software cannot rely on read-modify-write.
rsvd_zero_a: assert property (pwc_read_s
    |=> (o_apb.prdata & ~`WKCTL_PWC_MASK) == '0)
    else $error("reserved bits read nonzero");
ready_read_a: assert property (pwc_read_s |=> o_apb.prdata[`WKCTL_B_READY] == $past(rdy))
    else $error("ready bit read wrong");
ready_time_a: assert property (srst_s |-> ##READY_LAT rdy)
    else $error("ready not back after settling");
ready_stay_a: assert property (rdy && !do_srst |=> rdy)
    else $error("ready dropped without reset");
srst_clear_a: assert property (srst_s |=> !st.lan_wake_enable && !st.wake_pin_enable
    && !st.lan_wake_flag && st.int_sts == '0)
    else $error("soft reset left control bits set");
keep_pol_a: assert property (srst_s |=> $stable(st.wake_out_polarity))
    else $error("polarity lost on soft reset");
early_any_a: assert property (i_apb.psel && i_apb.penable && o_apb.pready && i_apb.pwrite
    && !rdy |=> $stable(st.int_en) && $stable(st.lan_wake_enable))
    else $error("early write honoured");

endmodule // wkctl_top

// ==== verification/wkctl_top_tb.sv ====
// Self-checking testbench of the wake control block.
`timescale 1ns/1ns
`include "wkctl_defines.svh"
module wkctl_top_tb import wkctl_pkg::*;;
    logic clk, rst, evt_req, lan_evt, line, irq, re;
    logic [31:0] rv, d, cfg;
    wkctl_apb_req_s req;
    wkctl_apb_rsp_s rsp;
    wkctl_pin_s pin;
    int n_fail, n_checks;
    wkctl_top #(.PULSE_CYC(20)) uut (.i_clk_sys(clk), .i_rst(rst), .i_apb(req), .o_apb(rsp),
        .i_lan_wake_evt(lan_evt), .o_wake_event_out(pin), .o_irq(irq));
    wkctl_wake_partner mac (.i_clk_sys(clk), .i_pin(pin), .i_evt_req(evt_req),
        .o_lan_wake_evt(lan_evt), .o_line(line));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chkb(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    // Every signal changes just after a rising edge and holds until pready is seen.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            end_of_test();
        end
        rv = rsp.prdata;
        re = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic set_evt(input logic v);
        @(posedge clk);
        evt_req <= v;
    endtask
    // Active line level: open-drain always pulls low, push-pull follows polarity.
    function automatic logic lvl(input logic [31:0] c);
        return c[6] ? c[2] : 1'b0;
    endfunction
    initial begin
        req = '0;
        evt_req = 0;
        rst = 1;
        n_fail = 0;
        n_checks = 0;
        d = $urandom(32'hb88fd112);
        repeat (10) @(posedge clk);
        rst <= 0;
        apb(0, `WKCTL_OFF_PWC, 0);
        chk(rv, 32'h0);
        apb(1, `WKCTL_OFF_PWC, 32'h24e);
        settle(20);
        apb(0, `WKCTL_OFF_PWC, 0);
        chk(rv, 32'h1);
        apb(0, `WKCTL_OFF_HARDWARE_CONFIG_REG, 0);
        chk(rv, 32'h0800_0000);
        apb(0, `WKCTL_OFF_INT_STS, 0);
        chk(rv, 32'h1);
        apb(1, `WKCTL_OFF_INT_EN, 32'h3);
        settle(1);
        chkb(irq, 1'b1);
        apb(1, `WKCTL_OFF_INT_STS, 32'h3);
        settle(1);
        chkb(irq, 1'b0);
        apb(0, 12'h100, 0);
        chkb(re, 1'b1);
        repeat (8) begin
            d = $urandom;
            apb(1, `WKCTL_OFF_PWC, d);
            apb(0, `WKCTL_OFF_PWC, 0);
            chk(rv, (d & 32'h24e) | 32'h1);
        end
        for (int i = 0; i < 4; i++) begin
            cfg = 32'h20a | (32'(i[1]) << 6) | (32'(i[0]) << 2);
            apb(1, `WKCTL_OFF_PWC, cfg);
            settle(2);
            chkb(line, ~lvl(cfg));
            set_evt(1);
            settle(4);
            chkb(line, lvl(cfg));
            apb(1, `WKCTL_OFF_PWC, cfg | 32'h20);
            apb(0, `WKCTL_OFF_PWC, 0);
            chkb(rv[5], 1'b1);
            set_evt(0);
            apb(1, `WKCTL_OFF_PWC, cfg | 32'h20);
            settle(3);
            chkb(line, ~lvl(cfg));
            apb(0, `WKCTL_OFF_PWC, 0);
            chkb(rv[5], 1'b0);
        end
        apb(1, `WKCTL_OFF_PWC, 32'h246);
        set_evt(1);
        settle(4);
        chkb(line, 1'b1);
        set_evt(0);
        settle(8);
        set_evt(1);
        settle(14);
        chkb(line, 1'b1);
        set_evt(0);
        settle(12);
        chkb(line, 1'b0);
        apb(1, `WKCTL_OFF_INT_STS, 32'h3);
        apb(1, `WKCTL_OFF_PWC, 32'h228);
        set_evt(1);
        settle(4);
        chkb(line, 1'b1);
        apb(0, `WKCTL_OFF_INT_STS, 0);
        chkb(rv[1], 1'b1);
        set_evt(0);
        apb(1, `WKCTL_OFF_PWC, 32'h266);
        apb(1, `WKCTL_OFF_HARDWARE_CONFIG_REG, 32'h1);
        apb(0, `WKCTL_OFF_PWC, 0);
        chk(rv, 32'h44);
        settle(20);
        apb(0, `WKCTL_OFF_PWC, 0);
        chk(rv, 32'h45);
        end_of_test();
    end
endmodule // wkctl_top_tb

// ==== verification/wkctl_wake_partner.sv ====
// Far-side model: host MAC wake event source and the pulled-up wake line.
`timescale 1ns/1ns
module wkctl_wake_partner import wkctl_pkg::*; (
    input wire logic i_clk_sys,
    input wkctl_pin_s i_pin,
    input wire logic i_evt_req,
    output logic o_lan_wake_evt,
    output logic o_line
);
    // The MAC holds its event until its own source is cleared by the bench.
    always_ff @(posedge i_clk_sys) begin
        o_lan_wake_evt <= i_evt_req;
    end
    // A released open-drain line floats up to the pull-up level.
    assign o_line = i_pin.oe ? i_pin.o : 1'b1;
endmodule // wkctl_wake_partner
